// ==== tb/nccd_top_chk.sv ====
// checker: decode figures and sequencing relations seen at the decoder's ports
`timescale 1ns/1ps
module nccd_top_chk (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic I_CE,
    input wire logic I_MCYC_EN,
    input wire nccd_pkg::nccd_op_e I_OP,
    input wire logic I_OP_VALID,
    input wire logic [13:0] I_TARGET,
    input wire logic [1:0] I_NEXT_LEN,
    input wire logic I_NEXT_IS_REF,
    input wire logic I_WAKE,
    input wire logic O_OP_READY,
    input wire logic O_BUSY,
    input wire logic O_UNDEFINED,
    input wire logic [1:0] O_LEN,
    input wire logic [2:0] O_CYCLES,
    input wire logic O_SKIP,
    input wire logic [2:0] O_SKIP_CYCLES,
    input wire logic [13:0] O_PC,
    input wire logic O_STOP
);
    // accept and tick strobes; the sequencer does not advance without both enables
    logic acc;
    logic tick;
    assign tick = I_CE && I_MCYC_EN;
    assign acc = tick && O_OP_READY && I_OP_VALID;
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);

    a_carry_op_len: assert property (
        acc && I_OP inside {nccd_pkg::OP_CARRY_SET, nccd_pkg::OP_CARRY_CLEAR,
        nccd_pkg::OP_CARRY_INVERT} |=> O_LEN == 2'h1 && O_CYCLES == 3'h1)
        else $error("carry op length or cycles wrong");
    a_long_call_len: assert property (
        acc && I_OP == nccd_pkg::OP_LONG_CALL |=> O_LEN == 2'h3 && O_CYCLES == 3'h4)
        else $error("long call length or cycles wrong");
    a_short_jump_done: assert property (
        acc && I_OP == nccd_pkg::OP_SHORT_JUMP ##1 tick [*2] |=> O_OP_READY)
        else $error("short jump not done after two ticks");
    a_page_jump_pc: assert property (
        acc && I_OP == nccd_pkg::OP_PAGE_JUMP ##1 tick [*2] |=>
        O_PC[11:0] == $past(I_TARGET[11:0]) && O_PC[13:12] == $past(O_PC[13:12]))
        else $error("page jump target wrong");
    a_accept_goes_busy: assert property (
        acc && I_OP < nccd_pkg::OP_UNDEFINED |=> O_BUSY && !O_OP_READY)
        else $error("accepted op did not start");
    a_no_tick_freeze: assert property (
        O_BUSY && !tick |=> O_BUSY && $stable(O_PC))
        else $error("state moved without a tick");
    a_undef_refused: assert property (
        acc && I_OP == nccd_pkg::OP_UNDEFINED |=> O_UNDEFINED && O_OP_READY)
        else $error("undefined op was executed");
    a_skip_penalty: assert property (
        $rose(O_SKIP) |-> O_SKIP_CYCLES ==
        (($past(I_NEXT_IS_REF) || $past(I_NEXT_LEN) != 2'h3) ? 3'h1 : 3'h2))
        else $error("skip penalty wrong");
    a_stop_holds: assert property (
        O_STOP && !I_WAKE |=> O_STOP)
        else $error("stop left without wake");

    // main scenarios reached
    c_skip_taken: cover property ($rose(O_SKIP));
    c_undefined: cover property (acc && I_OP == nccd_pkg::OP_UNDEFINED);
    c_stop: cover property ($rose(O_STOP));
endmodule : nccd_top_chk

bind nccd_top nccd_top_chk u_chk (.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .I_CE(I_CE),
    .I_MCYC_EN(I_MCYC_EN), .I_OP(I_OP), .I_OP_VALID(I_OP_VALID), .I_TARGET(I_TARGET),
    .I_NEXT_LEN(I_NEXT_LEN), .I_NEXT_IS_REF(I_NEXT_IS_REF), .I_WAKE(I_WAKE),
    .O_OP_READY(O_OP_READY), .O_BUSY(O_BUSY), .O_UNDEFINED(O_UNDEFINED), .O_LEN(O_LEN),
    .O_CYCLES(O_CYCLES), .O_SKIP(O_SKIP), .O_SKIP_CYCLES(O_SKIP_CYCLES), .O_PC(O_PC),
    .O_STOP(O_STOP));

// ==== tb/tb_top.sv ====
// testbench: table model of lengths, cycles and skips compared at every defined operation
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin error_cnt++; \
    $display("[ERR] %0t got %0h expected %0h", $time, a, b); end end
module tb_top;
    logic I_REF_CLK = 1'b0, I_RESETN = 1'b0, I_CE = 1'b1, I_MCYC_EN = 1'b1;
    logic I_OP_VALID = 1'b0, I_FLAG_MEM_BANK = 1'b0, I_FLAG_REG_BANK = 1'b0;
    logic I_CMP_EQUAL = 1'b0, I_STEP_CARRY = 1'b0, I_NEXT_IS_REF = 1'b0, I_WAKE = 1'b0;
    nccd_pkg::nccd_op_e I_OP = nccd_pkg::OP_NOP;
    logic [13:0] I_TARGET = 14'h0000;
    logic [1:0] I_NEXT_LEN = 2'h1;
    logic O_OP_READY, O_BUSY, O_UNDEFINED, O_SKIP, O_PC_LOAD, O_MEM_BANK_ENABLE;
    logic O_REG_BANK_ENABLE, O_IRQ_ENABLE, O_CARRY, O_IDLE, O_STOP;
    logic [1:0] O_LEN;
    logic [2:0] O_CYCLES, O_SKIP_CYCLES;
    logic [13:0] O_PC, p;
    integer seed = 62, error_cnt = 0, comparisons = 0, i, r;
    // per op id: bytes, machine cycles, skip kind (0 none, 1 equal, 2 carry, 3 always)
    string lens = "111122222212222122321223211121122211122111111122";
    string cycs = "111122222232222122322334333321122222122223311122";
    string conds = "000000000000111111000000000300000022000220000000";

    always #5 I_REF_CLK = ~I_REF_CLK;

    nccd_top uut (.I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .I_CE(I_CE),
        .I_MCYC_EN(I_MCYC_EN), .I_OP(I_OP), .I_OP_VALID(I_OP_VALID), .I_TARGET(I_TARGET),
        .I_FLAG_MEM_BANK(I_FLAG_MEM_BANK), .I_FLAG_REG_BANK(I_FLAG_REG_BANK),
        .I_CMP_EQUAL(I_CMP_EQUAL), .I_STEP_CARRY(I_STEP_CARRY), .I_NEXT_LEN(I_NEXT_LEN),
        .I_NEXT_IS_REF(I_NEXT_IS_REF), .I_WAKE(I_WAKE), .O_OP_READY(O_OP_READY),
        .O_BUSY(O_BUSY), .O_UNDEFINED(O_UNDEFINED), .O_LEN(O_LEN), .O_CYCLES(O_CYCLES),
        .O_SKIP(O_SKIP), .O_SKIP_CYCLES(O_SKIP_CYCLES), .O_PC(O_PC), .O_PC_LOAD(O_PC_LOAD),
        .O_MEM_BANK_ENABLE(O_MEM_BANK_ENABLE), .O_REG_BANK_ENABLE(O_REG_BANK_ENABLE),
        .O_IRQ_ENABLE(O_IRQ_ENABLE), .O_CARRY(O_CARRY), .O_IDLE(O_IDLE), .O_STOP(O_STOP));

    // random gaps in the machine-cycle tick and clock enable stretch every count
    always @(posedge I_REF_CLK) begin
        #1;
        r = $random(seed);
        I_MCYC_EN = r[0] | r[1];
        I_CE = r[2] | r[3] | r[4];
    end

    task automatic summarize();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    // one operation: request, wait for accept, count ticks until ready, compare model
    task automatic run(input int op);
        integer v, n, k, cond, pen;
        logic sk;
        begin
            v = $random(seed);
            I_OP = nccd_pkg::nccd_op_e'(op[5:0]);
            I_NEXT_IS_REF = v[2];
            I_NEXT_LEN = v[2] ? 2'h1 : (v[1:0] == 2'h0 ? 2'h3 : v[1:0]);
            I_CMP_EQUAL = v[3];
            I_STEP_CARRY = v[4];
            I_TARGET = v[18:5];
            I_FLAG_MEM_BANK = v[19];
            I_FLAG_REG_BANK = v[20];
            I_OP_VALID = 1'b1;
            k = 0;
            do begin
                @(posedge I_REF_CLK);
                k++;
            end while (!(I_CE && I_MCYC_EN && O_OP_READY) && k < 100);
            #1 I_OP_VALID = 1'b0;
            if (k >= 100) error_cnt++;
            if (op > 47) begin
                `CHK(O_UNDEFINED, 1'b1)
                `CHK(O_OP_READY, 1'b1)
            end else begin
                cond = conds[op] - 8'h30;
                sk = cond == 3 || (cond == 1 && v[3]) || (cond == 2 && v[4]);
                pen = !sk ? 0 : (v[2] || I_NEXT_LEN != 2'h3) ? 1 : 2;
                n = 0;
                k = 0;
                while (!(O_OP_READY || O_IDLE || O_STOP) && k < 200) begin
                    @(posedge I_REF_CLK);
                    if (I_CE && I_MCYC_EN) n++;
                    #1 k++;
                end
                if (k >= 200) error_cnt++;
                `CHK(n, cycs[op] - 8'h30 + pen)
                `CHK(O_LEN, 2'(lens[op] - 8'h30))
                `CHK(O_CYCLES, 3'(cycs[op] - 8'h30))
                `CHK(O_SKIP, sk)
                `CHK(O_SKIP_CYCLES, 3'(pen))
                `CHK(O_UNDEFINED, 1'b0)
                if (op == 6 || op == 7) begin
                    // a few idle cycles first, so the halt is seen holding without wake
                    repeat (3) @(posedge I_REF_CLK);
                    #1 `CHK(op == 7 ? O_STOP : O_IDLE, 1'b1)
                    I_WAKE = 1'b1;
                    k = 0;
                    while ((O_IDLE || O_STOP || !O_OP_READY) && k < 50) begin
                        @(posedge I_REF_CLK);
                        #1 k++;
                    end
                    if (k >= 50) error_cnt++;
                    I_WAKE = 1'b0;
                end
            end
        end
    endtask : run

    initial begin
        repeat (4) @(posedge I_REF_CLK);
        #1 I_RESETN = 1'b1;
        `CHK(O_OP_READY, 1'b1)
        `CHK(O_PC, 14'h0000)
        for (r = 0; r < 3; r++) begin
            for (i = 0; i < 48; i++) begin
                if (i != 6 && i != 7) run(i);
            end
        end
        run(48);
        run(63);
        run(6);
        run(7);
        // carry state follows set, invert, invert, clear
        run(1);
        `CHK(O_CARRY, 1'b1)
        run(3);
        `CHK(O_CARRY, 1'b0)
        run(3);
        `CHK(O_CARRY, 1'b1)
        run(2);
        `CHK(O_CARRY, 1'b0)
        run(4);
        `CHK(O_IRQ_ENABLE, 1'b1)
        run(5);
        `CHK(O_IRQ_ENABLE, 1'b0)
        run(11);
        `CHK({O_MEM_BANK_ENABLE, O_REG_BANK_ENABLE}, {I_FLAG_MEM_BANK, I_FLAG_REG_BANK})
        `CHK(O_PC, I_TARGET)
        // page jump and short call keep the upper pc bits of the current location
        run(18);
        `CHK(O_PC, I_TARGET)
        `CHK(O_PC_LOAD, 1'b1)
        p = I_TARGET;
        run(19);
        `CHK(O_PC, {p[13:12], I_TARGET[11:0]})
        p = O_PC;
        run(24);
        `CHK(O_PC, {p[13:11], I_TARGET[10:0]})
        run(20);
        summarize();
    end

    // watchdog well beyond the thousand or fewer cycles the sequence needs
    initial begin
        #500000;
        error_cnt++;
        summarize();
    end
endmodule : tb_top

// ==== verilog/nccd_dec_if.sv ====
// interface: decode result passed from the table to the sequencer
`timescale 1ns/1ps
interface nccd_dec_if;
    logic [1:0] len;
    logic [2:0] cycles;
    nccd_pkg::nccd_skipcond_e skip_cond;
    logic valid;
    logic is_ref;
    modport table_side (output len, output cycles, output skip_cond, output valid,
        output is_ref);
    modport seq_side (input len, input cycles, input skip_cond, input valid, input is_ref);
endinterface : nccd_dec_if

// ==== verilog/nccd_pkg.sv ====
// package: operation codes, lengths, cycle counts and skip figures for the decoder
package nccd_pkg;
    // operations decoded; opcode bit layouts are out of scope, so the core hands in an op id
    typedef enum logic [5:0] {
        OP_NOP, OP_CARRY_SET, OP_CARRY_CLEAR, OP_CARRY_INVERT,
        OP_IRQ_ON, OP_IRQ_OFF, OP_IDLE, OP_STOP,
        OP_MEM_BANK_SEL, OP_REG_BANK_SEL, OP_REF, OP_VECTOR_ENTRY,
        OP_CMP_R_IMM, OP_CMP_HL_IMM, OP_CMP_A_R, OP_CMP_A_HL, OP_CMP_EA_HL, OP_CMP_EA_RR,
        OP_LONG_JUMP, OP_PAGE_JUMP, OP_SHORT_JUMP, OP_JUMP_WX, OP_JUMP_EA,
        OP_LONG_CALL, OP_SHORT_CALL, OP_RET, OP_IRQ_RET, OP_RET_SKIP,
        OP_SWAP_DA, OP_SWAP_RA, OP_SWAP_IND, OP_SWAP_EA_DA, OP_SWAP_EA_RR, OP_SWAP_EA_HL,
        OP_SWAP_INC, OP_SWAP_DEC, OP_MOVE_1B, OP_MOVE_2B, OP_MOVE_PAIR_IMM,
        OP_FETCH_INC, OP_FETCH_DEC, OP_CODE_FETCH_WX, OP_CODE_FETCH_EA,
        OP_ROTATE_RC, OP_PUSH_PAIR, OP_POP_PAIR, OP_PUSH_BANKS, OP_POP_BANKS,
        OP_UNDEFINED
    } nccd_op_e;

    typedef enum logic [1:0] {
        SKC_NONE, SKC_EQUAL, SKC_CARRY, SKC_ALWAYS
    } nccd_skipcond_e;

    localparam logic [1:0] LEN_1 = 2'h1;
    localparam logic [1:0] LEN_2 = 2'h2;
    localparam logic [1:0] LEN_3 = 2'h3;
    localparam logic [2:0] CYC_1 = 3'h1;
    localparam logic [2:0] CYC_2 = 3'h2;
    localparam logic [2:0] CYC_3 = 3'h3;
    localparam logic [2:0] CYC_4 = 3'h4;
    localparam logic [2:0] SKIP_SHORT = 3'h1;   // skipped op of 1 or 2 bytes
    localparam logic [2:0] SKIP_LONG = 3'h2;    // skipped op of 3 bytes
    localparam logic [2:0] SKIP_REF = 3'h1;     // table reference always one cycle
    localparam int LONG_ADDR_W = 14;
    localparam int PAGE_ADDR_W = 12;
    localparam int SHORT_SUBROUTINE_CALL_ADDR_W = 11;
    localparam int PC_W = 14;
    localparam logic [13:0] PC_RESET = 14'h0000;
endpackage : nccd_pkg

// ==== verilog/nccd_skip_calc.sv ====
// module: extra machine cycles needed to skip the following operation
`timescale 1ns/1ps
module nccd_skip_calc (
    input wire logic i_skip,
    input wire logic [1:0] i_next_len,
    input wire logic i_next_is_ref,
    output logic [2:0] o_penalty
);
    // a table reference is skipped in one cycle whatever it points at
    always_comb begin
        if (!i_skip) begin
            o_penalty = 3'h0;
        end else if (i_next_is_ref) begin
            o_penalty = nccd_pkg::SKIP_REF;
        end else if (i_next_len == nccd_pkg::LEN_3) begin
            o_penalty = nccd_pkg::SKIP_LONG;
        end else begin
            o_penalty = nccd_pkg::SKIP_SHORT;
        end
    end
endmodule : nccd_skip_calc

// ==== verilog/nccd_table.sv ====
// module: length, cycle count and skip condition for each operation
`timescale 1ns/1ps
module nccd_table (
    input wire nccd_pkg::nccd_op_e i_op,
    nccd_dec_if.table_side o_dec
);
    // one row per operation; unlisted forms fall to the default and are refused
    always_comb begin
        o_dec.len = nccd_pkg::LEN_1;
        o_dec.cycles = nccd_pkg::CYC_1;
        o_dec.skip_cond = nccd_pkg::SKC_NONE;
        o_dec.valid = 1'b1;
        o_dec.is_ref = 1'b0;
        case (i_op)
            nccd_pkg::OP_NOP, nccd_pkg::OP_CARRY_SET, nccd_pkg::OP_CARRY_CLEAR,
            nccd_pkg::OP_CARRY_INVERT: begin
                o_dec.len = nccd_pkg::LEN_1;
                o_dec.cycles = nccd_pkg::CYC_1;
            end
            nccd_pkg::OP_IRQ_ON, nccd_pkg::OP_IRQ_OFF, nccd_pkg::OP_IDLE,
            nccd_pkg::OP_STOP, nccd_pkg::OP_VECTOR_ENTRY: begin
                o_dec.len = nccd_pkg::LEN_2;
                o_dec.cycles = nccd_pkg::CYC_2;
            end
            nccd_pkg::OP_MEM_BANK_SEL, nccd_pkg::OP_REG_BANK_SEL: begin
                o_dec.len = nccd_pkg::LEN_2;
                o_dec.cycles = nccd_pkg::CYC_2;
            end
            nccd_pkg::OP_REF: begin
                o_dec.len = nccd_pkg::LEN_1;
                o_dec.cycles = nccd_pkg::CYC_3;
                o_dec.is_ref = 1'b1;
            end
            nccd_pkg::OP_CMP_R_IMM, nccd_pkg::OP_CMP_HL_IMM, nccd_pkg::OP_CMP_A_R,
            nccd_pkg::OP_CMP_EA_HL, nccd_pkg::OP_CMP_EA_RR: begin
                o_dec.len = nccd_pkg::LEN_2;
                o_dec.cycles = nccd_pkg::CYC_2;
                o_dec.skip_cond = nccd_pkg::SKC_EQUAL;
            end
            nccd_pkg::OP_CMP_A_HL: begin
                o_dec.len = nccd_pkg::LEN_1;
                o_dec.cycles = nccd_pkg::CYC_1;
                o_dec.skip_cond = nccd_pkg::SKC_EQUAL;
            end
            nccd_pkg::OP_LONG_JUMP: begin
                o_dec.len = nccd_pkg::LEN_3;
                o_dec.cycles = nccd_pkg::CYC_3;
            end
            nccd_pkg::OP_PAGE_JUMP: begin
                o_dec.len = nccd_pkg::LEN_2;
                o_dec.cycles = nccd_pkg::CYC_2;
            end
            nccd_pkg::OP_SHORT_JUMP: begin
                o_dec.len = nccd_pkg::LEN_1;
                o_dec.cycles = nccd_pkg::CYC_2;
            end
            nccd_pkg::OP_JUMP_WX, nccd_pkg::OP_JUMP_EA: begin
                o_dec.len = nccd_pkg::LEN_2;
                o_dec.cycles = nccd_pkg::CYC_3;
            end
            nccd_pkg::OP_LONG_CALL: begin
                o_dec.len = nccd_pkg::LEN_3;
                o_dec.cycles = nccd_pkg::CYC_4;
            end
            nccd_pkg::OP_SHORT_CALL: begin
                o_dec.len = nccd_pkg::LEN_2;
                o_dec.cycles = nccd_pkg::CYC_3;
            end
            nccd_pkg::OP_RET, nccd_pkg::OP_IRQ_RET: begin
                o_dec.len = nccd_pkg::LEN_1;
                o_dec.cycles = nccd_pkg::CYC_3;
            end
            nccd_pkg::OP_RET_SKIP: begin
                o_dec.len = nccd_pkg::LEN_1;
                o_dec.cycles = nccd_pkg::CYC_3;
                o_dec.skip_cond = nccd_pkg::SKC_ALWAYS;
            end
            nccd_pkg::OP_SWAP_INC, nccd_pkg::OP_SWAP_DEC, nccd_pkg::OP_FETCH_INC,
            nccd_pkg::OP_FETCH_DEC: begin
                o_dec.len = nccd_pkg::LEN_1;
                o_dec.cycles = nccd_pkg::CYC_2;
                o_dec.skip_cond = nccd_pkg::SKC_CARRY;
            end
            nccd_pkg::OP_CODE_FETCH_WX, nccd_pkg::OP_CODE_FETCH_EA: begin
                o_dec.len = nccd_pkg::LEN_1;
                o_dec.cycles = nccd_pkg::CYC_3;
            end
            nccd_pkg::OP_ROTATE_RC, nccd_pkg::OP_SWAP_RA, nccd_pkg::OP_SWAP_IND,
            nccd_pkg::OP_MOVE_1B, nccd_pkg::OP_PUSH_PAIR,
            nccd_pkg::OP_POP_PAIR: begin
                o_dec.len = nccd_pkg::LEN_1;
                o_dec.cycles = nccd_pkg::CYC_1;
            end
            nccd_pkg::OP_PUSH_BANKS, nccd_pkg::OP_POP_BANKS, nccd_pkg::OP_MOVE_PAIR_IMM,
            nccd_pkg::OP_SWAP_DA, nccd_pkg::OP_SWAP_EA_DA, nccd_pkg::OP_SWAP_EA_RR,
            nccd_pkg::OP_SWAP_EA_HL, nccd_pkg::OP_MOVE_2B: begin
                o_dec.len = nccd_pkg::LEN_2;
                o_dec.cycles = nccd_pkg::CYC_2;
            end
            default: begin
                o_dec.valid = 1'b0;
            end
        endcase
    end
endmodule : nccd_table

// ==== verilog/nccd_top.sv ====
// module: control-transfer decoder and machine-cycle sequencer of the nibble core
`timescale 1ns/1ps
module nccd_top (
    input wire logic I_REF_CLK,
    input wire logic I_RESETN,
    input wire logic I_CE,
    input wire logic I_MCYC_EN,
    input wire nccd_pkg::nccd_op_e I_OP,
    input wire logic I_OP_VALID,
    input wire logic [13:0] I_TARGET,
    input wire logic I_FLAG_MEM_BANK,
    input wire logic I_FLAG_REG_BANK,
    input wire logic I_CMP_EQUAL,
    input wire logic I_STEP_CARRY,
    input wire logic [1:0] I_NEXT_LEN,
    input wire logic I_NEXT_IS_REF,
    input wire logic I_WAKE,
    output logic O_OP_READY,
    output logic O_BUSY,
    output logic O_UNDEFINED,
    output logic [1:0] O_LEN,
    output logic [2:0] O_CYCLES,
    output logic O_SKIP,
    output logic [2:0] O_SKIP_CYCLES,
    output logic [13:0] O_PC,
    output logic O_PC_LOAD,
    output logic O_MEM_BANK_ENABLE,
    output logic O_REG_BANK_ENABLE,
    output logic O_IRQ_ENABLE,
    output logic O_CARRY,
    output logic O_IDLE,
    output logic O_STOP
);
    typedef enum logic [1:0] {
        ST_IDLE, ST_EXEC, ST_SKIP, ST_HALT
    } nccd_state_e;

    nccd_dec_if dec ();

    nccd_state_e state_q, state_d;
    nccd_pkg::nccd_op_e op_q;
    logic [2:0] cnt_q, cnt_d;
    logic [1:0] len_q;
    logic [2:0] cyc_q;
    logic skip_q;
    logic [2:0] skip_cyc_q;
    logic [13:0] pc_q;
    logic pc_load_q;
    logic mbe_q, rbe_q, irq_q, carry_q, idle_q, stop_q, undef_q;
    logic [2:0] penalty;

    nccd_table u_table (
        .i_op(I_OP),
        .o_dec(dec)
    );

    nccd_pkg::nccd_skipcond_e dec_skip_cond_q;

    // skip decision sampled at the last execute cycle, when flags are settled
    wire skip_hit = (op_q != nccd_pkg::OP_UNDEFINED) &&
        ((dec_skip_cond_q == nccd_pkg::SKC_ALWAYS) ||
         (dec_skip_cond_q == nccd_pkg::SKC_EQUAL && I_CMP_EQUAL) ||
         (dec_skip_cond_q == nccd_pkg::SKC_CARRY && I_STEP_CARRY));

    nccd_skip_calc u_skip (
        .i_skip(skip_hit),
        .i_next_len(I_NEXT_LEN),
        .i_next_is_ref(I_NEXT_IS_REF),
        .o_penalty(penalty)
    );

    // state only advances on a machine-cycle tick of the selected cpu clock
    wire tick = I_CE && I_MCYC_EN;
    wire accept = (state_q == ST_IDLE) && I_OP_VALID;
    wire last_exec = (state_q == ST_EXEC) && (cnt_q == 3'h1);
    wire last_skip = (state_q == ST_SKIP) && (cnt_q == 3'h1);

    assign O_OP_READY = (state_q == ST_IDLE);
    assign O_BUSY = (state_q != ST_IDLE);

    // sequencer next state
    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_IDLE: begin
                if (I_OP_VALID && dec.valid) begin
                    state_d = ST_EXEC;
                    cnt_d = dec.cycles;
                end
            end
            ST_EXEC: begin
                if (cnt_q != 3'h1) begin
                    cnt_d = cnt_q - 3'h1;
                end else if (op_q == nccd_pkg::OP_STOP) begin
                    state_d = ST_HALT;
                end else if (penalty != 3'h0) begin
                    state_d = ST_SKIP;
                    cnt_d = penalty;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_SKIP: begin
                if (cnt_q != 3'h1) begin
                    cnt_d = cnt_q - 3'h1;
                end else begin
                    state_d = ST_IDLE;
                end
            end
            ST_HALT: begin
                if (I_WAKE) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // sequencer registers
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_q <= ST_IDLE;
            cnt_q <= 3'h0;
        end else if (tick) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // latch the decode of the accepted operation so outputs hold during execution
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            op_q <= nccd_pkg::OP_NOP;
            len_q <= 2'h0;
            cyc_q <= 3'h0;
            dec_skip_cond_q <= nccd_pkg::SKC_NONE;
            undef_q <= 1'b0;
        end else if (tick && accept) begin
            op_q <= dec.valid ? I_OP : nccd_pkg::OP_UNDEFINED;
            len_q <= dec.len;
            cyc_q <= dec.cycles;
            dec_skip_cond_q <= dec.skip_cond;
            undef_q <= !dec.valid;
        end
    end

    // skip result is held from the end of execution until the next accept
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            skip_q <= 1'b0;
            skip_cyc_q <= 3'h0;
        end else if (tick && accept) begin
            skip_q <= 1'b0;
            skip_cyc_q <= 3'h0;
        end else if (tick && last_exec) begin
            skip_q <= skip_hit;
            skip_cyc_q <= penalty;
        end
    end

    // target width masks per transfer kind; high bits kept from current pc
    wire [13:0] long_tgt = I_TARGET[13:0];
    wire [13:0] page_tgt = {pc_q[13:12], I_TARGET[11:0]};
    wire [13:0] short_subroutine_call_tgt = {pc_q[13:11], I_TARGET[10:0]};
    wire is_long = (op_q == nccd_pkg::OP_LONG_JUMP) || (op_q == nccd_pkg::OP_LONG_CALL) ||
        (op_q == nccd_pkg::OP_VECTOR_ENTRY);
    wire is_page = (op_q == nccd_pkg::OP_PAGE_JUMP);
    wire is_short_subroutine_call = (op_q == nccd_pkg::OP_SHORT_CALL);
    wire is_rel = (op_q == nccd_pkg::OP_SHORT_JUMP) || (op_q == nccd_pkg::OP_JUMP_WX) ||
        (op_q == nccd_pkg::OP_JUMP_EA) || (op_q == nccd_pkg::OP_RET) ||
        (op_q == nccd_pkg::OP_IRQ_RET) || (op_q == nccd_pkg::OP_RET_SKIP);
    wire [13:0] pc_next = is_page ? page_tgt : (is_short_subroutine_call ? short_subroutine_call_tgt : long_tgt);
    wire pc_write = is_long || is_page || is_short_subroutine_call || is_rel;

    // program counter load on the last execute cycle of a transfer
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            pc_q <= nccd_pkg::PC_RESET;
            pc_load_q <= 1'b0;
        end else if (I_CE) begin
            pc_load_q <= tick && last_exec && pc_write;
            if (tick && last_exec && pc_write) begin
                pc_q <= pc_next;
            end
        end
    end

    // cpu control flags; irq and carry edits take effect at the end of execution
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            mbe_q <= 1'b0;
            rbe_q <= 1'b0;
            irq_q <= 1'b0;
            carry_q <= 1'b0;
        end else if (tick && last_exec) begin
            case (op_q)
                nccd_pkg::OP_VECTOR_ENTRY: begin
                    mbe_q <= I_FLAG_MEM_BANK;
                    rbe_q <= I_FLAG_REG_BANK;
                end
                nccd_pkg::OP_CARRY_SET: carry_q <= 1'b1;
                nccd_pkg::OP_CARRY_CLEAR: carry_q <= 1'b0;
                nccd_pkg::OP_CARRY_INVERT: carry_q <= !carry_q;
                nccd_pkg::OP_IRQ_ON: irq_q <= 1'b1;
                nccd_pkg::OP_IRQ_OFF: irq_q <= 1'b0;
                default: begin
                end
            endcase
        end
    end

    // power modes: idle lasts until wake, stop follows its two cycles
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            idle_q <= 1'b0;
            stop_q <= 1'b0;
        end else if (I_CE) begin
            if (I_WAKE) begin
                idle_q <= 1'b0;
                stop_q <= 1'b0;
            end else if (tick && last_exec && op_q == nccd_pkg::OP_IDLE) begin
                idle_q <= 1'b1;
            end else if (tick && last_exec && op_q == nccd_pkg::OP_STOP) begin
                stop_q <= 1'b1;
            end
        end
    end

    assign O_UNDEFINED = undef_q;
    assign O_LEN = len_q;
    assign O_CYCLES = cyc_q;
    assign O_SKIP = skip_q;
    assign O_SKIP_CYCLES = skip_cyc_q;
    assign O_PC = pc_q;
    assign O_PC_LOAD = pc_load_q;
    assign O_MEM_BANK_ENABLE = mbe_q;
    assign O_REG_BANK_ENABLE = rbe_q;
    assign O_IRQ_ENABLE = irq_q;
    assign O_CARRY = carry_q;
    assign O_IDLE = idle_q;
    assign O_STOP = stop_q;
endmodule : nccd_top
